// *** hw/lrcs_sequencer.sv ***
// Flow sequencer: program counter, call stack, repeat and loop control.
// Assumes the decoder presents one command per enabled cycle and holds
// it off while busy_out is high; bus transfers come from the decoder.
`timescale 1ns/1ns
`include "lrcs_consts.svh"

module lrcs_sequencer (
	// Clock, reset and enable
	input  wire logic                    clock_in,
	input  wire logic                    rst_in,
	input  wire logic                    enable_in,
	// Decoded flow command
	input  wire lrcs_pkg::lrcs_cmd_t     cmd_in,
	// Interrupt request and vector
	input  wire logic                    irq_in,
	input  wire logic [`LRCS_WORD_W-1:0] irq_vector_in,
	// Inter-register transfer
	input  wire lrcs_pkg::lrcs_xfer_t    xfer_in,
	output logic [`LRCS_WORD_W-1:0]      xfer_data_out,
	// Program flow
	output logic [`LRCS_WORD_W-1:0]      pc_out,
	output logic                         busy_out,
	output logic                         repeating_out,
	output logic                         irq_taken_out,
	output logic                         loop_end_out,
	output logic [`LRCS_WORD_W-1:0]      repeat_count_out,
	output logic [`LRCS_WORD_W-1:0]      loop_nesting_depth_out
);

	typedef enum logic [1:0] {
		ST_RUN,
		ST_FLUSH,
		ST_REP_IDLE,
		ST_REP
	} lrcs_state_t;

	lrcs_state_t                   state;
	logic [`LRCS_WORD_W-1:0]       pc;
	logic [`LRCS_WORD_W-1:0]       repeat_count;
	logic [`LRCS_WORD_W-1:0]       loop_first_address;
	logic [`LRCS_WORD_W-1:0]       loop_last_address;
	logic [`LRCS_WORD_W-1:0]       loop_iteration_count;
	logic [`LRCS_DEPTH_W-1:0]      loop_nesting_depth;
	logic [`LRCS_CALL_PTR_W-1:0]   call_stack_pointer;
	logic [`LRCS_WORD_W-1:0]       call_stack_memory [`LRCS_CALL_DEPTH];
	lrcs_pkg::lrcs_level_t         loop_save_file [`LRCS_LOOP_LEVELS];

	logic                          issue;
	logic                          take_irq;
	logic                          at_loop_end;
	logic                          loop_done;
	logic                          push_call;
	logic                          pop_call;
	logic                          save_level;
	logic                          restore_level;
	logic                          rd_saved_first;
	logic                          wr_saved_first;
	logic [`LRCS_WORD_W-1:0]       next_pc;
	logic [`LRCS_WORD_W-1:0]       jump_target;
	logic [`LRCS_WORD_W-1:0]       pc_plus_one;
	logic [`LRCS_DEPTH_W-1:0]      depth_up;
	logic [`LRCS_CALL_PTR_W-1:0]   call_up;
	lrcs_pkg::lrcs_level_t         top_level;
	logic [`LRCS_DEPTH_W-1:0]      top_index;
	lrcs_state_t                   next_state;
	logic [`LRCS_WORD_W-1:0]       next_repeat_count;
	logic [`LRCS_DEPTH_W-1:0]      next_depth;

	function automatic logic [`LRCS_WORD_W-1:0] inc16(
		input logic [`LRCS_WORD_W-1:0] v);
		inc16 = v + `LRCS_WORD_W'h1;
	endfunction

	function automatic logic [`LRCS_DEPTH_W-1:0] lvl(
		input logic [`LRCS_DEPTH_W-1:0] d);
		// Entry index from depth; wraps silently past four levels
		lvl = d - `LRCS_DEPTH_W'h1;
	endfunction

	assign issue = enable_in && (state == ST_RUN);
	// Interrupts held off through the whole repeat sequence
	assign take_irq = issue && irq_in;
	assign pc_plus_one = inc16(pc);
	assign depth_up = loop_nesting_depth + `LRCS_DEPTH_W'h1;
	assign call_up = call_stack_pointer + `LRCS_CALL_PTR_W'h1;
	assign top_index = lvl(loop_nesting_depth);
	assign top_level = loop_save_file[top_index[1:0]];

	// Relative offset or pointer value
	assign jump_target = cmd_in.indirect ? cmd_in.pointer
		: pc + cmd_in.value;

	assign at_loop_end = issue && !take_irq
		&& (loop_nesting_depth != `LRCS_DEPTH_W'h0)
		&& (pc == loop_last_address);
	assign loop_done = at_loop_end
		&& (loop_iteration_count == `LRCS_WORD_W'h1);

	assign push_call = take_irq
		|| (issue && cmd_in.op == lrcs_pkg::LRCS_OP_CALL);
	assign pop_call = issue && !take_irq
		&& (cmd_in.op == lrcs_pkg::LRCS_OP_EXIT
		|| cmd_in.op == lrcs_pkg::LRCS_OP_INT_EXIT);
	assign save_level = issue && !take_irq
		&& cmd_in.op == lrcs_pkg::LRCS_OP_LOOP;
	assign restore_level = loop_done || (issue && !take_irq
		&& cmd_in.op == lrcs_pkg::LRCS_OP_DISCARD);
	assign rd_saved_first = enable_in && xfer_in.read
		&& xfer_in.sel == `LRCS_SEL_SAVED_FIRST;
	assign wr_saved_first = enable_in && xfer_in.write
		&& xfer_in.sel == `LRCS_SEL_SAVED_FIRST;

	always_comb
	begin
		next_pc = pc;
		if (take_irq)
			next_pc = irq_vector_in;
		else if (issue)
		begin
			unique case (cmd_in.op)
				lrcs_pkg::LRCS_OP_JUMP,
				lrcs_pkg::LRCS_OP_CALL:
					next_pc = jump_target;
				lrcs_pkg::LRCS_OP_EXIT,
				lrcs_pkg::LRCS_OP_INT_EXIT:
					next_pc = call_stack_memory[call_stack_pointer];
				lrcs_pkg::LRCS_OP_REPEAT:
					next_pc = pc_plus_one;
				lrcs_pkg::LRCS_OP_NONE,
				lrcs_pkg::LRCS_OP_LOOP,
				lrcs_pkg::LRCS_OP_DISCARD:
					// Discard leaves flow to a following jump
					if (at_loop_end && !loop_done)
						next_pc = loop_first_address;
					else
						next_pc = pc_plus_one;
				default:
					next_pc = pc_plus_one;
			endcase
		end
	end

	// Branches purge one fetched slot: two cycles total
	always_comb
	begin
		next_state = state;
		unique case (state)
			ST_RUN:
				if (take_irq
					|| cmd_in.op == lrcs_pkg::LRCS_OP_JUMP
					|| cmd_in.op == lrcs_pkg::LRCS_OP_CALL
					|| cmd_in.op == lrcs_pkg::LRCS_OP_EXIT
					|| cmd_in.op == lrcs_pkg::LRCS_OP_INT_EXIT)
					next_state = ST_FLUSH;
				else if (cmd_in.op == lrcs_pkg::LRCS_OP_REPEAT)
					next_state = ST_REP_IDLE;
			ST_FLUSH:
				next_state = ST_RUN;
			ST_REP_IDLE:
				next_state = ST_REP;
			ST_REP:
				// Leave on the last pass, no lost cycle
				if (repeat_count <= `LRCS_WORD_W'h1)
					next_state = ST_RUN;
		endcase
	end

	always_ff @(posedge clock_in)
	begin
		if (rst_in)
			state <= ST_RUN;
		else if (enable_in)
			state <= next_state;
	end

	always_ff @(posedge clock_in)
	begin
		if (rst_in)
			pc <= `LRCS_WORD_W'h0;
		else if (enable_in)
			pc <= next_pc;
	end

	// Repeat counter lives off the bus
	always_comb
	begin
		next_repeat_count = repeat_count;
		if (issue && !take_irq
			&& cmd_in.op == lrcs_pkg::LRCS_OP_REPEAT)
			next_repeat_count = cmd_in.value & `LRCS_REP_MAX;
		else if (state == ST_REP)
			next_repeat_count = repeat_count - `LRCS_WORD_W'h1;
	end

	always_ff @(posedge clock_in)
	begin
		if (rst_in)
			repeat_count <= `LRCS_WORD_W'h0;
		else if (enable_in)
			repeat_count <= next_repeat_count;
	end

	// Call stack: pre-increment push, post-decrement pop
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
			call_stack_pointer <= `LRCS_CALL_PTR_W'h0;
		else if (enable_in)
		begin
			if (push_call)
				call_stack_pointer <= call_up;
			else if (pop_call)
				call_stack_pointer <= call_stack_pointer
					- `LRCS_CALL_PTR_W'h1;
			else if (xfer_in.write && xfer_in.sel == `LRCS_SEL_CALL_PTR)
				call_stack_pointer <= xfer_in.data[`LRCS_CALL_PTR_W-1:0];
		end
	end

	// Depth sized by parameter; overflow wraps the pointer
	always_ff @(posedge clock_in)
	begin
		if (enable_in && push_call)
			call_stack_memory[call_up] <= take_irq ? pc
				: pc_plus_one;
	end

	always_comb
	begin
		next_depth = loop_nesting_depth;
		if (save_level || wr_saved_first)
			next_depth = depth_up;
		else if (restore_level || rd_saved_first)
			next_depth = top_index;
		else if (xfer_in.write && xfer_in.sel == `LRCS_SEL_DEPTH)
			next_depth = xfer_in.data[`LRCS_DEPTH_W-1:0];
	end

	always_ff @(posedge clock_in)
	begin
		if (rst_in)
			loop_nesting_depth <= `LRCS_DEPTH_RESET;
		else if (enable_in)
			loop_nesting_depth <= next_depth;
	end

	// Beyond four levels entries are overwritten
	always_ff @(posedge clock_in)
	begin
		if (enable_in)
		begin
			if (save_level)
				loop_save_file[loop_nesting_depth[1:0]] <=
					{loop_first_address, loop_last_address,
					loop_iteration_count};
			else if (wr_saved_first)
				loop_save_file[loop_nesting_depth[1:0]].first <=
					xfer_in.data;
			else if (xfer_in.write
				&& xfer_in.sel == `LRCS_SEL_SAVED_LAST)
				loop_save_file[top_index[1:0]].last <=
					xfer_in.data;
			else if (xfer_in.write
				&& xfer_in.sel == `LRCS_SEL_SAVED_COUNT)
				loop_save_file[top_index[1:0]].count <=
					xfer_in.data;
		end
	end

	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			loop_first_address   <= `LRCS_WORD_W'h0;
			loop_last_address    <= `LRCS_WORD_W'h0;
			loop_iteration_count <= `LRCS_WORD_W'h0;
		end
		else if (enable_in)
		begin
			if (save_level)
			begin
				loop_first_address   <= pc_plus_one;
				loop_last_address    <= cmd_in.loop_end;
				loop_iteration_count <= cmd_in.value;
			end
			else if (restore_level)
			begin
				loop_first_address   <= top_level.first;
				loop_last_address    <= top_level.last;
				loop_iteration_count <= top_level.count;
			end
			else if (at_loop_end)
				loop_iteration_count <= loop_iteration_count
					- `LRCS_WORD_W'h1;
			else if (xfer_in.write)
			begin
				unique case (xfer_in.sel)
					`LRCS_SEL_FIRST: loop_first_address <= xfer_in.data;
					`LRCS_SEL_LAST:  loop_last_address <= xfer_in.data;
					`LRCS_SEL_COUNT: loop_iteration_count <= xfer_in.data;
					default: ;
				endcase
			end
		end
	end

	// Read data and status straight from flip-flops
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			xfer_data_out          <= `LRCS_WORD_W'h0;
			pc_out                 <= `LRCS_WORD_W'h0;
			busy_out               <= 1'b0;
			repeating_out          <= 1'b0;
			irq_taken_out          <= 1'b0;
			loop_end_out           <= 1'b0;
			repeat_count_out       <= `LRCS_WORD_W'h0;
			loop_nesting_depth_out <= `LRCS_WORD_W'h0;
		end
		else if (enable_in)
		begin
			pc_out                 <= next_pc;
			// Status shows the state after this edge, so busy never lags
			busy_out               <= (next_state != ST_RUN);
			repeating_out          <= (next_state == ST_REP);
			irq_taken_out          <= take_irq;
			loop_end_out           <= loop_done;
			repeat_count_out       <= next_repeat_count;
			loop_nesting_depth_out <= {13'h0, next_depth};
			if (xfer_in.read)
			begin
				unique case (xfer_in.sel)
					`LRCS_SEL_FIRST: xfer_data_out <= loop_first_address;
					`LRCS_SEL_LAST:  xfer_data_out <= loop_last_address;
					`LRCS_SEL_COUNT: xfer_data_out <= loop_iteration_count;
					`LRCS_SEL_SAVED_FIRST: xfer_data_out <= top_level.first;
					`LRCS_SEL_SAVED_LAST:  xfer_data_out <= top_level.last;
					`LRCS_SEL_SAVED_COUNT: xfer_data_out <= top_level.count;
					`LRCS_SEL_DEPTH:
						xfer_data_out <= {13'h0, loop_nesting_depth};
					`LRCS_SEL_CALL_PTR:
						xfer_data_out <= {12'h0, call_stack_pointer};
				endcase
			end
		end
	end

endmodule

// *** hw/lrcs_consts.svh ***
// Constants of the loop, repeat and call sequencer.
// Assumes one core instruction clock and a decoder that issues
// one flow-control command per instruction cycle.
//
// Summary of operation
// - Call pre-increments pointer, then pushes return address
// - Relative target adds offset; pointer target loads directly
// - Exit pops program counter, then decrements pointer
// - Call and exit take jump timing, two cycles
// - Interrupt pushes fetch address, loads vector; exit returns
// - Sixteen-bit repeat count holds remaining repetitions
// - Loop first and last addresses held separately
// - Loop count loaded at start, decremented per pass
// - Four-entry save file holds three words per level
// - Save file reachable through three bus ports
// - First-address port read pre-decrements, write post-increments
// - Nesting beyond four entries loses saved state
// - Depth pointer three live bits, upper bits zero
// - Depth pointer resets to zero, bus accessible
// - Depth follows loop saves and restores
// - Flow registers except repeat count, program counter and call stack words on bus
// - Repeat covers next instruction, count 1 to 32767
// - No interrupt accepted while repeating
// - Repeat loads count, one idle cycle first
// - Program counter held while repeating, count decrements
// - Repeat ends without lost cycle, save file untouched
// - Loop start pushes old values, loads new ones
// - At last address decrement, branch or restore at one
// - Discard restores one level, program counter unchanged
`ifndef LRCS_CONSTS_SVH
`define LRCS_CONSTS_SVH

`define LRCS_WORD_W        16
`define LRCS_CALL_DEPTH    16
`define LRCS_CALL_PTR_W    4
`define LRCS_LOOP_LEVELS   4
`define LRCS_DEPTH_W       3
`define LRCS_DEPTH_RESET   3'h0
`define LRCS_REP_MAX       16'h7fff
`define LRCS_JUMP_CYCLES   2

// Register selects on the inter-register transfer port
`define LRCS_SEL_FIRST     3'h0
`define LRCS_SEL_LAST      3'h1
`define LRCS_SEL_COUNT     3'h2
`define LRCS_SEL_SAVED_FIRST 3'h3
`define LRCS_SEL_SAVED_LAST  3'h4
`define LRCS_SEL_SAVED_COUNT 3'h5
`define LRCS_SEL_DEPTH     3'h6
`define LRCS_SEL_CALL_PTR  3'h7

`endif

// *** hw/lrcs_pkg.sv ***
// Types of the loop, repeat and call sequencer.
// Assumes the constants header is on the include path.
`include "lrcs_consts.svh"

package lrcs_pkg;

	typedef enum logic [3:0] {
		LRCS_OP_NONE,
		LRCS_OP_JUMP,
		LRCS_OP_CALL,
		LRCS_OP_EXIT,
		LRCS_OP_INT_EXIT,
		LRCS_OP_REPEAT,
		LRCS_OP_LOOP,
		LRCS_OP_DISCARD
	} lrcs_op_t;

	typedef struct packed {
		lrcs_op_t                 op;
		logic                     indirect;
		logic [`LRCS_WORD_W-1:0]  value;
		logic [`LRCS_WORD_W-1:0]  pointer;
		logic [`LRCS_WORD_W-1:0]  loop_end;
	} lrcs_cmd_t;

	typedef struct packed {
		logic                     read;
		logic                     write;
		logic [2:0]               sel;
		logic [`LRCS_WORD_W-1:0]  data;
	} lrcs_xfer_t;

	typedef struct packed {
		logic [`LRCS_WORD_W-1:0] first;
		logic [`LRCS_WORD_W-1:0] last;
		logic [`LRCS_WORD_W-1:0] count;
	} lrcs_level_t;

endpackage

// *** bench/lrcs_sequencer_chk.sv ***
// Port checker of the flow sequencer.
// Assumes a bind onto lrcs_sequencer; sees only its ports.
`timescale 1ns/1ns
`include "lrcs_consts.svh"
module lrcs_sequencer_chk (
	input wire logic                 clock_in,
	input wire logic                 rst_in,
	input wire logic                 enable_in,
	input wire lrcs_pkg::lrcs_cmd_t  cmd_in,
	input wire logic                 irq_in,
	input wire logic [15:0]          irq_vector_in,
	input wire lrcs_pkg::lrcs_xfer_t xfer_in,
	input wire logic [15:0]          pc_out,
	input wire logic                 busy_out,
	input wire logic                 repeating_out,
	input wire logic                 irq_taken_out,
	input wire logic [15:0]          repeat_count_out,
	input wire logic [15:0]          loop_nesting_depth_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (rst_in);
	logic run;
	assign run = enable_in && !busy_out;
	depth_upper_a: assert property (loop_nesting_depth_out[15:3] == 13'h0)
		else $error("depth upper bits set");
	depth_reset_a: assert property ($fell(rst_in) |-> !loop_nesting_depth_out)
		else $error("depth not zero after reset");
	irq_hold_a: assert property (enable_in && busy_out && irq_in
		|=> !irq_taken_out)
		else $error("interrupt taken while busy");
	irq_vec_a: assert property (irq_taken_out |-> pc_out == $past(irq_vector_in))
		else $error("interrupt target not loaded");
	rep_dec_a: assert property (enable_in && repeating_out ##1 repeating_out
		|-> repeat_count_out == $past(repeat_count_out) - 16'h1)
		else $error("repeat count not decremented");
	rep_pc_a: assert property (repeating_out ##1 repeating_out |-> $stable(pc_out))
		else $error("pc moved while repeating");
	call_time_a: assert property (run && cmd_in.op == lrcs_pkg::LRCS_OP_CALL
		|=> busy_out ##1 !busy_out)
		else $error("call timing wrong");
	port_push_a: assert property (enable_in && xfer_in.write
		&& xfer_in.sel == `LRCS_SEL_SAVED_FIRST
		|=> loop_nesting_depth_out == $past(loop_nesting_depth_out) + 16'h1)
		else $error("depth not raised by port write");
	port_pop_a: assert property (enable_in && xfer_in.read
		&& xfer_in.sel == `LRCS_SEL_SAVED_FIRST
		|=> loop_nesting_depth_out == $past(loop_nesting_depth_out) - 16'h1)
		else $error("depth not lowered by port read");
	loop_push_a: assert property (run && !irq_in
		&& cmd_in.op == lrcs_pkg::LRCS_OP_LOOP
		|=> loop_nesting_depth_out == $past(loop_nesting_depth_out) + 16'h1)
		else $error("loop start did not raise depth");
	discard_a: assert property (run && !irq_in
		&& cmd_in.op == lrcs_pkg::LRCS_OP_DISCARD
		|=> loop_nesting_depth_out == $past(loop_nesting_depth_out) - 16'h1)
		else $error("discard did not lower depth");
	cover property (irq_taken_out);
	cover property (repeating_out ##1 !repeating_out);
	cover property (run && cmd_in.op == lrcs_pkg::LRCS_OP_LOOP);
endmodule

// *** bench/lrcs_sequencer_tb.sv ***
// Self-checking bench of the flow sequencer.
// Assumes design and checker compiled first; inputs move on falling edges.
`timescale 1ns/1ns
`include "lrcs_consts.svh"
module lrcs_sequencer_tb;
	logic                 clock_in;
	logic                 rst_in;
	logic                 enable_in;
	logic                 irq_in;
	logic [15:0]          irq_vector_in;
	lrcs_pkg::lrcs_cmd_t  cmd_in;
	lrcs_pkg::lrcs_xfer_t xfer_in;
	logic [15:0]          xfer_data_out;
	logic [15:0]          pc_out;
	logic                 busy_out;
	logic                 repeating_out;
	logic                 irq_taken_out;
	logic                 loop_end_out;
	logic [15:0]          repeat_count_out;
	logic [15:0]          loop_nesting_depth_out;
	int                   bad_count;
	int                   check_count;
	int                   n;
	int                   c;
	logic [31:0]          seed;
	logic [15:0]          p;
	logic [15:0]          v;
	logic [15:0]          w;

	lrcs_sequencer dut (
		.clock_in, .rst_in, .enable_in, .cmd_in, .irq_in, .irq_vector_in,
		.xfer_in, .xfer_data_out, .pc_out, .busy_out, .repeating_out,
		.irq_taken_out, .loop_end_out, .repeat_count_out,
		.loop_nesting_depth_out
	);

	initial
	begin
		clock_in = 1'b0;
		forever #2 clock_in = ~clock_in;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic stop_test();
		$display("checks=%0d bad=%0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic tick(input int k);
		repeat (k) @(negedge clock_in);
	endtask

	// Bounded wait so a stuck busy cannot hang the run
	task automatic idle();
		int i;
		i = 0;
		while (busy_out !== 1'b0 && i < 100)
		begin
			tick(1);
			i++;
		end
	endtask

	task automatic op(input lrcs_pkg::lrcs_op_t o, input logic ind,
		input logic [15:0] val, input logic [15:0] ptr);
		idle();
		cmd_in = '{o, ind, val, ptr, ptr};
		tick(1);
		cmd_in.op = lrcs_pkg::LRCS_OP_NONE;
	endtask

	// Idle edge after each transfer so no signal is set twice in a step
	task automatic xf(input logic rd, input logic [2:0] s,
		input logic [15:0] d);
		xfer_in = '{rd, !rd, s, d};
		tick(1);
		xfer_in = '0;
		tick(1);
	endtask

	initial
	begin
		seed = 32'hb836f255;
		bad_count = 0;
		check_count = 0;
		rst_in = 1'b1;
		enable_in = 1'b1;
		irq_in = 1'b0;
		irq_vector_in = 16'h0;
		cmd_in = '0;
		xfer_in = '0;
		tick(6);
		check(loop_nesting_depth_out, 16'h0);
		check(pc_out, 16'h0);
		rst_in = 1'b0;
		for (int i = 0; i < 5; i++)
		begin
			xf(1'b0, `LRCS_SEL_DEPTH, 16'(i));
			xf(1'b1, `LRCS_SEL_DEPTH, 16'h0);
			check(xfer_data_out, 16'(i));
		end
		xf(1'b0, `LRCS_SEL_DEPTH, 16'h1);
		v = 16'(rnd());
		w = 16'(rnd());
		xf(1'b0, `LRCS_SEL_SAVED_FIRST, v);
		check(loop_nesting_depth_out, 16'h2);
		xf(1'b0, `LRCS_SEL_SAVED_LAST, w);
		xf(1'b1, `LRCS_SEL_SAVED_LAST, 16'h0);
		check(xfer_data_out, w);
		xf(1'b1, `LRCS_SEL_SAVED_FIRST, 16'h0);
		check(xfer_data_out, v);
		check(loop_nesting_depth_out, 16'h1);
		xf(1'b0, `LRCS_SEL_DEPTH, 16'h0);
		w = 16'(rnd());
		xf(1'b0, `LRCS_SEL_COUNT, w);
		n = 2 + rnd() % 100;
		// End address far from pc so no pass completes meanwhile
		v = 16'h8000 | 16'(rnd());
		op(lrcs_pkg::LRCS_OP_LOOP, 1'b0, 16'(n), v);
		check(loop_nesting_depth_out, 16'h1);
		xf(1'b1, `LRCS_SEL_COUNT, 16'h0);
		check(xfer_data_out, 16'(n));
		xf(1'b1, `LRCS_SEL_LAST, 16'h0);
		check(xfer_data_out, v);
		xf(1'b1, `LRCS_SEL_SAVED_COUNT, 16'h0);
		check(xfer_data_out, w);
		op(lrcs_pkg::LRCS_OP_DISCARD, 1'b0, 16'h0, 16'h0);
		check(loop_nesting_depth_out, 16'h0);
		xf(1'b1, `LRCS_SEL_COUNT, 16'h0);
		check(xfer_data_out, w);
		for (int k = 0; k < 4; k++)
		begin
			n = (k == 0) ? 1 : 1 + rnd() % 8;
			op(lrcs_pkg::LRCS_OP_REPEAT, 1'b0, 16'(n), 16'h0);
			irq_in = 1'b1;
			c = 0;
			while (busy_out === 1'b1 && c < 40)
			begin
				c++;
				tick(1);
			end
			irq_in = 1'b0;
			check(16'(c), 16'(n + 1));
			check(16'(irq_taken_out), 16'h0);
		end
		op(lrcs_pkg::LRCS_OP_REPEAT, 1'b0, 16'h8, 16'h0);
		// Enable low in the idle cycle after repeat must keep the loaded count
		enable_in = 1'b0;
		tick(3);
		check(repeat_count_out, 16'h8);
		enable_in = 1'b1;
		idle();
		v = 16'(rnd());
		irq_vector_in = v;
		irq_in = 1'b1;
		tick(1);
		irq_in = 1'b0;
		check(16'(irq_taken_out), 16'h1);
		check(pc_out, v);
		xf(1'b1, `LRCS_SEL_CALL_PTR, 16'h0);
		check(xfer_data_out, 16'h1);
		op(lrcs_pkg::LRCS_OP_INT_EXIT, 1'b0, 16'h0, 16'h0);
		for (int k = 0; k < 4; k++)
		begin
			idle();
			p = pc_out;
			v = 16'(rnd());
			op(lrcs_pkg::LRCS_OP_CALL, k[0], v, v);
			check(pc_out, k[0] ? v : p + v);
			xf(1'b1, `LRCS_SEL_CALL_PTR, 16'h0);
			check(xfer_data_out, 16'h1);
			op(lrcs_pkg::LRCS_OP_EXIT, 1'b0, 16'h0, 16'h0);
			check(pc_out, p + 16'h1);
			xf(1'b1, `LRCS_SEL_CALL_PTR, 16'h0);
			check(xfer_data_out, 16'h0);
		end
		for (int k = 0; k < 2; k++)
		begin
			n = (k == 0) ? 1 : 2 + rnd() % 7;
			idle();
			p = pc_out;
			// Two-instruction body right after the loop command
			op(lrcs_pkg::LRCS_OP_LOOP, 1'b0, 16'(n), p + 16'h2);
			c = 0;
			while (loop_end_out !== 1'b1 && c < 100)
			begin
				tick(1);
				c++;
			end
			check(16'(c), 16'(2 * n));
			check(pc_out, p + 16'h3);
			check(loop_nesting_depth_out, 16'h0);
		end
		stop_test();
	end

	initial
	begin
		#(4 * 20000);
		bad_count++;
		stop_test();
	end
endmodule

bind lrcs_sequencer lrcs_sequencer_chk chk (
	.clock_in, .rst_in, .enable_in, .cmd_in, .irq_in, .irq_vector_in,
	.xfer_in, .pc_out, .busy_out, .repeating_out, .irq_taken_out,
	.repeat_count_out, .loop_nesting_depth_out
);
